// ==== logic/lmp_pkg.sv ====
/*
  Shared constants and types of the logical to physical sector mapper.
  Assumes a single clock domain; every user writes lmp_pkg::name.
*/
package lmp_pkg;
  // ==========================================================
  // Default logical geometry, used until the host sets its own
  localparam int DEF_CYLS = 16383;
  localparam int DEF_HEADS = 16;
  localparam int DEF_SPT = 63;
  localparam int FIRST_SECTOR = 1;
  // ==========================================================
  // Physical track layout and spare provisioning
  localparam int PHYS_SECTORS = 408;
  localparam int DATA_SECTORS = 406;
  localparam int RESERVE_SLOTS = 2;
  localparam int SLIP_POOL = 255;
  localparam int SLIP_POOL_CYLS = 60;
  localparam int SPARE_CYLS = 4;
  localparam int ALT_THRESHOLD = 3;
  // ==========================================================
  // Identification data words carrying the addressable geometry
  localparam logic [7:0] ID_WORD_CYLS = 8'h36;
  localparam logic [7:0] ID_WORD_HEADS = 8'h37;
  localparam logic [7:0] ID_WORD_SPT = 8'h38;
  // ==========================================================
  // Defect table entry kinds
  localparam logic KIND_SLIP = 1'b0;
  localparam logic KIND_ALT = 1'b1;
  localparam int POS_W = 32;
  localparam int ENTRY_W = POS_W + 1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SLIP = 3'b001,
    S_ALT  = 3'b010,
    S_OUT  = 3'b011,
    S_RWR  = 3'b100,
    S_RRD  = 3'b101,
    S_ADD  = 3'b110
  } lmp_state_t;
endpackage

// ==== logic/lmp_defect_mem.sv ====
/*
  Small defect table memory: one write port, one read port, registered read.
  Assumes the owner keeps addresses in range and ignores data it did not ask for.
*/
`timescale 1ns/100ps
module lmp_defect_mem #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // ==========================================================
  // Storage
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Array has no reset; the owner's entry count says what is valid
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Read data always comes from a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// ==== logic/lmp_mapper.sv ====
/*
  Logical to physical sector mapper: CHS or LBA address in, physical
  cylinder, head and sector out, with slip and alternate-cylinder remap.
  Assumes requests, geometry writes and error reports come from logic on clk.
*/
// Notes on behaviour
// - Every medium access is translated to physical cylinder, head, sector first.
// - Current mode uses the heads and sectors per track last set by host.
// - Without a host setting, geometry is 16383 cylinders, 16 heads, 63 sectors.
// - Geometry is reported in identification words 54 to 56.
// - CHS address zero maps to cylinder 0, head 0, sector 1.
// - After a head's last sector comes the next head's first sector.
// - LBA starts at 0/0/1 and rolls to the next track after last data sector.
// - Sectors 1 to 406 carry blocks; the two slots after are reserve spares.
// - Slip spare pool is 255 sectors per 60 cylinders; code keeps one drive-wide cap of 255 slips per started 60 cylinders.
// - Four spare cylinders are reserved for reassignment.
// - A slipped defect is skipped; it and later addresses move one slot on.
// - Tracks with three or more defects, and auto picks, go to alternates.
// - Reassigned sector goes to its alternate; later sectors return home.
// - The alternate cylinders lie on the inner side of the recording area.
// - Formatting clears the defect layout and restores default geometry.
// - Read recovered only with stronger correction triggers reassignment checks.
// - Recovered sector is rewritten and reread; reassign only if reread fails.
// - An unrecovered write error reassigns the sector to an alternate.
`timescale 1ns/100ps
module lmp_mapper #(
  parameter int PHYS_CYLS = 1024,
  parameter int PHYS_HEADS = 4,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic geo_set,
  input wire logic [4:0] geo_heads,
  input wire logic [7:0] geo_spt,
  output logic geo_default,
  input wire logic [7:0] id_word_sel,
  output logic [15:0] id_word_data,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_lba_mode,
  input wire logic [15:0] req_cyl,
  input wire logic [3:0] req_head,
  input wire logic [7:0] req_sector,
  input wire logic [27:0] req_lba,
  output logic map_valid,
  output logic map_error,
  output logic map_alternate,
  output logic [15:0] disk_cylinder_index,
  output logic [7:0] track_head_index,
  output logic [8:0] track_sector_index,
  input wire logic fmt_start,
  input wire logic fmt_add_valid,
  output logic fmt_add_ready,
  input wire logic [31:0] fmt_add_pos,
  input wire logic [7:0] fmt_track_defects,
  input wire logic err_valid,
  output logic err_ready,
  input wire logic err_read_recovered,
  output logic rewrite_req,
  input wire logic rewrite_done,
  output logic reread_req,
  input wire logic reread_done,
  input wire logic reread_ok,
  output logic reassign_done,
  output logic table_full
);
  // ==========================================================
  // Derived layout
  localparam int AW = $clog2(DEPTH);
  localparam int IW = $clog2(DEPTH + 1);
  localparam int ALT_BASE = PHYS_CYLS - lmp_pkg::SPARE_CYLS;
  localparam int USER_TRACKS = ALT_BASE * PHYS_HEADS;
  localparam int ALT_CYL_SLOTS = PHYS_HEADS * lmp_pkg::PHYS_SECTORS;
  localparam int ALT_CAP = lmp_pkg::SPARE_CYLS * ALT_CYL_SLOTS;
  localparam int SLIP_LIMIT = lmp_pkg::SLIP_POOL *
    ((PHYS_CYLS + lmp_pkg::SLIP_POOL_CYLS - 1) / lmp_pkg::SLIP_POOL_CYLS);

  lmp_pkg::lmp_state_t state_reg, state_next;
  logic [4:0] heads_reg;
  logic [7:0] spt_reg;
  logic [31:0] pos_reg, last_pos_reg;
  logic rng_reg, hit_reg, pend_reg, last_ok_reg;
  logic [IW-1:0] scan_reg, ent_cnt_reg, slip_cnt_reg, alt_cnt_reg, ord_cnt_reg, ord_reg;
  logic [lmp_pkg::ENTRY_W-1:0] rd_entry;

  // ==========================================================
  // Acceptance decode; formatting outranks errors, errors outrank maps
  wire idle = (state_reg == lmp_pkg::S_IDLE);
  wire fmt_go = idle & fmt_start;
  wire add_go = idle & ~fmt_start & fmt_add_valid;
  wire err_go = idle & ~fmt_start & ~fmt_add_valid & err_valid;
  wire req_go = idle & ~fmt_start & ~fmt_add_valid & ~err_valid & req_valid;
  wire geo_go = idle & geo_set & (geo_heads != 5'h00) & (geo_spt != 8'h00);
  assign fmt_add_ready = idle & ~fmt_start;
  assign err_ready = fmt_add_ready & ~fmt_add_valid;
  assign req_ready = err_ready & ~err_valid;
  assign rewrite_req = (state_reg == lmp_pkg::S_RWR);
  assign reread_req = (state_reg == lmp_pkg::S_RRD);

  // linear sector index
  // Computed at acceptance so geometry updates never mix into one request
  wire [31:0] chs_lin = (32'(req_cyl) * 32'(heads_reg) + 32'(req_head)) * 32'(spt_reg)
                        + 32'(req_sector) - 32'(lmp_pkg::FIRST_SECTOR);
  wire [31:0] req_lin = req_lba_mode ? 32'(req_lba) : chs_lin;
  wire req_bad = ~req_lba_mode & ((5'(req_head) >= heads_reg) | (req_sector == 8'h00)
                 | (req_sector > spt_reg));

  // ==========================================================
  // Defect table scan decode
  wire rd_kind = rd_entry[lmp_pkg::ENTRY_W-1];
  wire [31:0] rd_pos = rd_entry[lmp_pkg::POS_W-1:0];
  wire scan_more = (scan_reg < ent_cnt_reg);
  wire scan_done = ~pend_reg & ~scan_more;
  // slip shifts the address
  // Entries are stored in the order written; ascending writes let each bump see earlier bumps
  wire slip_bump = (state_reg == lmp_pkg::S_SLIP) & pend_reg & (rd_kind == lmp_pkg::KIND_SLIP)
                   & (rd_pos <= pos_reg);
  wire alt_seen = (state_reg == lmp_pkg::S_ALT) & pend_reg & (rd_kind == lmp_pkg::KIND_ALT);
  wire alt_match = alt_seen & (rd_pos == pos_reg) & ~hit_reg;

  // ==========================================================
  // Physical position from the remapped index
  // 406 data slots per track
  // next track after the last data slot
  wire [31:0] trk = pos_reg / 32'(lmp_pkg::DATA_SECTORS);
  wire [31:0] slot = 32'(ord_reg);
  wire [31:0] out_cyl = hit_reg ? 32'(ALT_BASE) + slot / 32'(ALT_CYL_SLOTS) : trk / 32'(PHYS_HEADS);
  wire [31:0] out_head = hit_reg ? (slot / 32'(lmp_pkg::PHYS_SECTORS)) % 32'(PHYS_HEADS)
                                 : trk % 32'(PHYS_HEADS);
  wire [31:0] out_sec = 32'(lmp_pkg::FIRST_SECTOR) + (hit_reg ? slot % 32'(lmp_pkg::PHYS_SECTORS)
                                                              : pos_reg % 32'(lmp_pkg::DATA_SECTORS));
  wire out_err = rng_reg | (~hit_reg & (trk >= 32'(USER_TRACKS)));

  // ==========================================================
  // Table writes; kind and room decided here
  // three defects go to alternates
  wire fmt_kind = ((fmt_track_defects >= 8'(lmp_pkg::ALT_THRESHOLD))
                   | (32'(slip_cnt_reg) >= 32'(SLIP_LIMIT))) ? lmp_pkg::KIND_ALT : lmp_pkg::KIND_SLIP;
  wire alt_room = (ent_cnt_reg < IW'(DEPTH)) & (32'(alt_cnt_reg) < 32'(ALT_CAP));
  wire slip_room = (ent_cnt_reg < IW'(DEPTH));
  wire add_room = (fmt_kind == lmp_pkg::KIND_ALT) ? alt_room : slip_room;
  wire auto_add = (state_reg == lmp_pkg::S_ADD);
  wire wr_en = (add_go & add_room) | (auto_add & alt_room);
  wire wr_alt = auto_add | (fmt_kind == lmp_pkg::KIND_ALT);
  wire [lmp_pkg::ENTRY_W-1:0] wr_data = auto_add ? {lmp_pkg::KIND_ALT, last_pos_reg}
                                                 : {fmt_kind, fmt_add_pos};
  wire drop = (add_go & ~add_room) | (auto_add & ~alt_room);

  lmp_defect_mem #(.WIDTH(lmp_pkg::ENTRY_W), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_addr(ent_cnt_reg[AW-1:0]),
    .wr_data(wr_data),
    .rd_addr(scan_reg[AW-1:0]),
    .rd_data(rd_entry)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lmp_pkg::S_IDLE: begin
        if (req_go) begin
          state_next = lmp_pkg::S_SLIP;
        end else if (err_go & last_ok_reg & err_read_recovered) begin
          state_next = lmp_pkg::S_RWR;
        end else if (err_go & last_ok_reg) begin
          state_next = lmp_pkg::S_ADD;
        end
      end
      lmp_pkg::S_SLIP: if (scan_done) begin
        state_next = lmp_pkg::S_ALT;
      end
      lmp_pkg::S_ALT: if (scan_done) begin
        state_next = lmp_pkg::S_OUT;
      end
      lmp_pkg::S_RWR: if (rewrite_done) begin
        state_next = lmp_pkg::S_RRD;
      end
      lmp_pkg::S_RRD: if (reread_done) begin
        state_next = reread_ok ? lmp_pkg::S_IDLE : lmp_pkg::S_ADD;
      end
      default: state_next = lmp_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= lmp_pkg::S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Scan pointer; read data lags the pointer by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_reg <= '0;
      pend_reg <= 1'b0;
    end else if ((state_reg == lmp_pkg::S_SLIP || state_reg == lmp_pkg::S_ALT) && !scan_done) begin
      scan_reg <= scan_more ? scan_reg + IW'(1) : scan_reg;
      pend_reg <= scan_more;
    end else begin
      scan_reg <= '0;
      pend_reg <= 1'b0;
    end
  end

  // Working address and alternate hit for the request in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= '0;
      rng_reg <= 1'b0;
      hit_reg <= 1'b0;
      ord_reg <= '0;
      ord_cnt_reg <= '0;
    end else if (req_go) begin
      pos_reg <= req_lin;
      rng_reg <= req_bad;
      hit_reg <= 1'b0;
      ord_cnt_reg <= '0;
    end else begin
      pos_reg <= slip_bump ? pos_reg + 32'd1 : pos_reg;
      hit_reg <= hit_reg | alt_match;
      ord_reg <= alt_match ? ord_cnt_reg : ord_reg;
      ord_cnt_reg <= alt_seen ? ord_cnt_reg + IW'(1) : ord_cnt_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      heads_reg <= 5'(lmp_pkg::DEF_HEADS);
      spt_reg <= 8'(lmp_pkg::DEF_SPT);
      geo_default <= 1'b1;
    end else if (fmt_go) begin
      heads_reg <= 5'(lmp_pkg::DEF_HEADS);
      spt_reg <= 8'(lmp_pkg::DEF_SPT);
      geo_default <= 1'b1;
    end else if (geo_go) begin
      heads_reg <= geo_heads;
      spt_reg <= geo_spt;
      geo_default <= 1'b0;
    end
  end

  // alternate entries counted apart from slips
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ent_cnt_reg <= '0;
      slip_cnt_reg <= '0;
      alt_cnt_reg <= '0;
      table_full <= 1'b0;
    end else if (fmt_go) begin
      ent_cnt_reg <= '0;
      slip_cnt_reg <= '0;
      alt_cnt_reg <= '0;
      table_full <= 1'b0;
    end else begin
      ent_cnt_reg <= wr_en ? ent_cnt_reg + IW'(1) : ent_cnt_reg;
      slip_cnt_reg <= (wr_en & ~wr_alt) ? slip_cnt_reg + IW'(1) : slip_cnt_reg;
      alt_cnt_reg <= (wr_en & wr_alt) ? alt_cnt_reg + IW'(1) : alt_cnt_reg;
      table_full <= table_full | drop;
    end
  end

  // Result registers; the last mapping is the reassign source, only when it was a clean home mapping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map_valid <= 1'b0;
      map_error <= 1'b0;
      map_alternate <= 1'b0;
      disk_cylinder_index <= '0;
      track_head_index <= '0;
      track_sector_index <= '0;
      last_pos_reg <= '0;
      last_ok_reg <= 1'b0;
      reassign_done <= 1'b0;
    end else begin
      map_valid <= (state_reg == lmp_pkg::S_OUT);
      reassign_done <= auto_add & alt_room;
      if (state_reg == lmp_pkg::S_OUT) begin
        map_error <= out_err;
        map_alternate <= hit_reg;
        disk_cylinder_index <= out_cyl[15:0];
        track_head_index <= out_head[7:0];
        track_sector_index <= out_sec[8:0];
        last_pos_reg <= pos_reg;
        last_ok_reg <= ~out_err & ~hit_reg;
      end else if (auto_add | fmt_go) begin
        last_ok_reg <= 1'b0;
      end
    end
  end

  // identification words 54 to 56
  // The device never learns the host's cylinder count, so word 54 stays default
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_word_data <= '0;
    end else begin
      case (id_word_sel)
        lmp_pkg::ID_WORD_CYLS: id_word_data <= 16'(lmp_pkg::DEF_CYLS);
        lmp_pkg::ID_WORD_HEADS: id_word_data <= 16'(heads_reg);
        lmp_pkg::ID_WORD_SPT: id_word_data <= 16'(spt_reg);
        default: id_word_data <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_map_done;
    req_go |-> ##[4:300] map_valid;
  endproperty
  a_map_done: assert property (p_map_done) else $error("request not mapped in time");

  property p_default_geo;
    geo_default |-> (heads_reg == 5'h10) && (spt_reg == 8'h3F);
  endproperty
  a_default_geo: assert property (p_default_geo) else $error("default geometry wrong");

  property p_geo_take;
    geo_go && !fmt_go |=> (spt_reg == $past(geo_spt)) && (heads_reg == $past(geo_heads)) && !geo_default;
  endproperty
  a_geo_take: assert property (p_geo_take) else $error("geometry not taken");

  property p_zero_map;
    (req_go && req_lba_mode && req_lba == 28'h0 && ent_cnt_reg == '0)
      |-> ##4 map_valid && disk_cylinder_index == 16'h0 && track_head_index == 8'h0
          && track_sector_index == 9'h1;
  endproperty
  a_zero_map: assert property (p_zero_map) else $error("block zero misplaced");

  property p_home_sector;
    map_valid && !map_alternate && !map_error |-> track_sector_index inside {[9'h1:9'h196]};
  endproperty
  a_home_sector: assert property (p_home_sector) else $error("reserve slot used");

  property p_alt_inner;
    map_valid && map_alternate |-> disk_cylinder_index >= 16'(ALT_BASE);
  endproperty
  a_alt_inner: assert property (p_alt_inner) else $error("alternate not inner");

  property p_reread_skip;
    (state_reg == lmp_pkg::S_RRD && reread_done && reread_ok)
      |=> idle ##1 ent_cnt_reg == $past(ent_cnt_reg, 2);
  endproperty
  a_reread_skip: assert property (p_reread_skip) else $error("reassigned after good reread");

  property p_rewrite_first;
    (err_go && last_ok_reg && err_read_recovered) |=> rewrite_req && !reread_req;
  endproperty
  a_rewrite_first: assert property (p_rewrite_first) else $error("no rewrite first");

  property p_write_fail;
    (err_go && last_ok_reg && !err_read_recovered && alt_room)
      |=> ##1 alt_cnt_reg == $past(alt_cnt_reg, 2) + IW'(1) && reassign_done;
  endproperty
  a_write_fail: assert property (p_write_fail) else $error("write failure not reassigned");

  property p_three_alt;
    (add_go && fmt_track_defects >= 8'h03 && alt_room) |=> alt_cnt_reg == $past(alt_cnt_reg) + IW'(1);
  endproperty
  a_three_alt: assert property (p_three_alt) else $error("dense track slipped");

  property p_slip_pool;
    32'(slip_cnt_reg) <= 32'(SLIP_LIMIT);
  endproperty
  a_slip_pool: assert property (p_slip_pool) else $error("slip pool exceeded");
endmodule

// ==== sim/lmp_media_model.sv ====
/*
  Medium side model: answers the rewrite and reread requests of the mapper.
  Assumes one clock shared with the mapper; reply speed and reread outcome come from the bench.
*/
`timescale 1ns/100ps
module lmp_media_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic ok_sel,
  input wire logic rewrite_req,
  input wire logic reread_req,
  output logic rewrite_done,
  output logic reread_done,
  output logic reread_ok
);
  // ==========================================================
  // Reply sequencing
  logic [3:0] wait_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 4'h0;
      rewrite_done <= 1'b0;
      reread_done <= 1'b0;
      reread_ok <= 1'b0;
    end else begin
      rewrite_done <= 1'b0;
      reread_done <= 1'b0;
      // Outcome toggles outside a reply so a stale value is never trusted
      reread_ok <= ~reread_ok;
      if ((rewrite_req || reread_req) && !rewrite_done && !reread_done) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg >= (slow ? 4'h6 : 4'h0)) begin
          wait_reg <= 4'h0;
          rewrite_done <= rewrite_req;
          reread_done <= reread_req & ~rewrite_req;
          reread_ok <= ok_sel;
        end
      end
    end
  end
endmodule

// ==== sim/tb.sv ====
/*
  Self-checking bench of the sector mapper: driver notes results, a monitor compares them.
  Assumes the mapper answers every taken request with one map_valid pulse.
*/
`timescale 1ns/100ps
module tb;
  localparam int CYL_COUNT = 1024;
  localparam int HEAD_COUNT = 4;
  localparam logic [34:0] ALL = 35'h7_FFFF_FFFF;
  localparam logic [34:0] ERR = 35'h4_0000_0000;
  logic clk, rst, geo_set, geo_default, req_valid, req_ready, req_lba_mode;
  logic map_valid, map_error, map_alternate, fmt_start, fmt_add_valid, fmt_add_ready;
  logic err_valid, err_ready, err_read_recovered, rewrite_req, rewrite_done, reread_req;
  logic reread_done, reread_ok, reassign_done, table_full, slow, ok_sel;
  logic [4:0] geo_heads;
  logic [7:0] geo_spt, id_word_sel, req_sector, track_head_index, fmt_track_defects;
  logic [15:0] id_word_data, req_cyl, disk_cylinder_index;
  logic [3:0] req_head;
  logic [27:0] req_lba;
  logic [8:0] track_sector_index;
  logic [31:0] fmt_add_pos;
  logic [34:0] exp_q[$], mask_q[$], e_cur, m_cur;
  int err_total, checks;

  lmp_mapper #(.PHYS_CYLS(CYL_COUNT), .PHYS_HEADS(HEAD_COUNT), .DEPTH(64)) uut (.clk(clk), .rst(rst),
    .geo_set(geo_set),
    .geo_heads(geo_heads), .geo_spt(geo_spt), .geo_default(geo_default), .id_word_sel(id_word_sel),
    .id_word_data(id_word_data), .req_valid(req_valid), .req_ready(req_ready), .req_lba_mode(req_lba_mode),
    .req_cyl(req_cyl), .req_head(req_head), .req_sector(req_sector), .req_lba(req_lba), .map_valid(map_valid),
    .map_error(map_error), .map_alternate(map_alternate), .disk_cylinder_index(disk_cylinder_index),
    .track_head_index(track_head_index), .track_sector_index(track_sector_index), .fmt_start(fmt_start),
    .fmt_add_valid(fmt_add_valid), .fmt_add_ready(fmt_add_ready), .fmt_add_pos(fmt_add_pos),
    .fmt_track_defects(fmt_track_defects), .err_valid(err_valid), .err_ready(err_ready),
    .err_read_recovered(err_read_recovered), .rewrite_req(rewrite_req), .rewrite_done(rewrite_done),
    .reread_req(reread_req), .reread_done(reread_done), .reread_ok(reread_ok),
    .reassign_done(reassign_done), .table_full(table_full));

  lmp_media_model media (.clk(clk), .rst(rst), .slow(slow), .ok_sel(ok_sel), .rewrite_req(rewrite_req),
    .reread_req(reread_req), .rewrite_done(rewrite_done), .reread_done(reread_done), .reread_ok(reread_ok));

  // ==========================================================
  // Clock and shared helpers
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic check(input logic [34:0] s, input logic [34:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Home slot of a linear index: 406 data slots a track, tracks fill heads first
  function automatic logic [34:0] home(input int idx);
    int trk;
    trk = idx / lmp_pkg::DATA_SECTORS;
    return {2'b00, 16'(trk / HEAD_COUNT), 8'(trk % HEAD_COUNT), 9'(idx % lmp_pkg::DATA_SECTORS + 1)};
  endfunction

  // Alternate slots are handed out in entry order on the inner spare cylinders
  function automatic logic [34:0] alt(input int ord);
    return {2'b01, 16'(CYL_COUNT - lmp_pkg::SPARE_CYLS), 8'(ord / lmp_pkg::PHYS_SECTORS),
      9'(ord % lmp_pkg::PHYS_SECTORS + 1)};
  endfunction

  // Monitor: oldest note against each result
  // Sampled at the falling edge, well away from the edge that launches the result
  always @(negedge clk) begin
    if (map_valid === 1'b1) begin
      e_cur = exp_q.size() > 0 ? exp_q.pop_front() : ~ALL;
      m_cur = mask_q.size() > 0 ? mask_q.pop_front() : ALL;
      check({map_error, map_alternate, disk_cylinder_index, track_head_index, track_sector_index} & m_cur,
        e_cur & m_cur);
    end
  end

  // Request held until taken, then waits for its result
  task automatic map(input logic lm, input int c, input int h, input int s, input int l, input logic [34:0] e,
    input logic [34:0] m);
    int n;
    @(negedge clk);
    req_lba_mode = lm;
    req_cyl = 16'(c);
    req_head = 4'(h);
    req_sector = 8'(s);
    req_lba = 28'(l);
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    // A request never taken counts as a mismatch
    if (n >= 200) begin
      err_total++;
    end
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (map_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    // A result that never comes counts as a mismatch
    if (n >= 300) begin
      err_total++;
    end
  endtask

  task automatic idw(input logic [7:0] sel, input int v);
    @(negedge clk);
    id_word_sel = sel;
    @(negedge clk);
    check(35'(id_word_data), 35'(v));
  endtask

  task automatic fmt_add(input int pos, input int d);
    @(negedge clk);
    fmt_add_pos = 32'(pos);
    fmt_track_defects = 8'(d);
    fmt_add_valid = 1'b1;
    do @(posedge clk); while (fmt_add_ready !== 1'b1);
    @(negedge clk);
    fmt_add_valid = 1'b0;
  endtask

  task automatic fmt_new;
    @(negedge clk);
    fmt_start = 1'b1;
    @(negedge clk);
    fmt_start = 1'b0;
    @(negedge clk);
    check(35'(geo_default), 35'h1);
  endtask

  // Error on the last mapped sector; notes whether a reassignment followed
  task automatic report(input logic rec, input logic ok, input logic sl, input logic want);
    logic seen;
    @(negedge clk);
    err_read_recovered = rec;
    ok_sel = ok;
    slow = sl;
    err_valid = 1'b1;
    do @(posedge clk); while (err_ready !== 1'b1);
    @(negedge clk);
    err_valid = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      seen = seen | (reassign_done === 1'b1);
    end
    check(35'(seen), 35'(want));
  endtask

  initial begin
    #(20000 * 40);
    err_total++;
    stop_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {geo_set, req_valid, req_lba_mode, fmt_start, fmt_add_valid, err_valid, err_read_recovered} = 7'h00;
    {slow, ok_sel, geo_heads, geo_spt, id_word_sel, fmt_track_defects} = 31'h0;
    {req_cyl, req_head, req_sector, req_lba, fmt_add_pos} = 88'h0;
    err_total = 0;
    checks = 0;
    void'($urandom(32'hD6C1));
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(35'(geo_default), 35'h1);
    idw(lmp_pkg::ID_WORD_CYLS, 16383);
    idw(lmp_pkg::ID_WORD_HEADS, 16);
    idw(lmp_pkg::ID_WORD_SPT, 63);
    idw(8'h00, 0);
    $display("test defaults done");
    // CHS walk inside the assumed cylinders
    map(1'b0, 0, 0, 1, 0, home(0), ALL);
    map(1'b0, 0, 0, 63, 0, home(62), ALL);
    map(1'b0, 0, 1, 1, 0, home(63), ALL);
    map(1'b0, 2, 3, 5, 0, home(2209), ALL);
    // LBA track rollover past the data slots
    map(1'b1, 0, 0, 0, 0, home(0), ALL);
    map(1'b1, 0, 0, 0, 405, home(405), ALL);
    map(1'b1, 0, 0, 0, 406, home(406), ALL);
    // random blocks stay inside the user tracks
    for (int i = 0; i < 8; i++) begin
      automatic int l = int'($urandom % 200000);
      map(1'b1, 0, 0, 0, l, home(l), ALL);
    end
    $display("test chs and lba done");
    // host geometry, smaller than the default capacity
    @(negedge clk);
    geo_heads = 5'h04;
    geo_spt = 8'h64;
    geo_set = 1'b1;
    @(negedge clk);
    geo_set = 1'b0;
    check(35'(geo_default), 35'h0);
    idw(lmp_pkg::ID_WORD_HEADS, 4);
    idw(lmp_pkg::ID_WORD_SPT, 100);
    map(1'b0, 1, 2, 5, 0, home(604), ALL);
    map(1'b0, 1, 3, 100, 0, home(799), ALL);
    // addresses outside the active geometry are flagged
    map(1'b0, 0, 4, 1, 0, ERR, ERR);
    map(1'b0, 0, 0, 0, 0, ERR, ERR);
    map(1'b0, 0, 0, 101, 0, ERR, ERR);
    $display("test geometry done");
    // slip moves the defect and later slots on
    fmt_new();
    fmt_add(4, 1);
    map(1'b1, 0, 0, 0, 3, home(3), ALL);
    map(1'b1, 0, 0, 0, 4, home(5), ALL);
    map(1'b1, 0, 0, 0, 5, home(6), ALL);
    // dense track goes to the inner alternate, next sector returns
    fmt_new();
    fmt_add(416, 3);
    map(1'b1, 0, 0, 0, 416, alt(0), ALL);
    map(1'b1, 0, 0, 0, 417, home(417), ALL);
    $display("test defects done");
    map(1'b1, 0, 0, 0, 1000, home(1000), ALL);
    report(1'b0, 1'b0, 1'b0, 1'b1);
    map(1'b1, 0, 0, 0, 1000, alt(1), ALL);
    map(1'b1, 0, 0, 0, 2000, home(2000), ALL);
    report(1'b1, 1'b1, 1'b1, 1'b0);
    map(1'b1, 0, 0, 0, 2000, home(2000), ALL);
    report(1'b1, 1'b0, 1'b0, 1'b1);
    map(1'b1, 0, 0, 0, 2000, alt(2), ALL);
    check(35'(table_full), 35'h0);
    $display("test reassignment done");
    repeat (4) @(negedge clk);
    check(35'(exp_q.size()), 35'h0);
    stop_test;
  end
endmodule
